/* File: core/pbf_defines.svh */
// constants for the packet buffer frame engine
`ifndef PBF_DEFINES_SVH
`define PBF_DEFINES_SVH

// word indices and byte sizes inside one packet
`define PBF_STATUS_IDX 10'h000
`define PBF_COUNT_IDX 10'h001
`define PBF_DATA_IDX 10'h002
`define PBF_DATA_OFFSET 12'h004
`define PBF_PAGE_BYTES 12'h800
`define PBF_MAX_DATA 12'h7FB
`define PBF_CRC_BYTES 12'h004
`define PBF_TRL_ODD 12'h005
`define PBF_TRL_EVEN 12'h006
`define PBF_HDR_WORDS 11'h003
`define PBF_DA_BYTES 12'h006

// on-wire length limits
`define PBF_MIN_FRAME 12'h040
`define PBF_MAX_FRAME 12'h5EE

// control byte fields
`define PBF_TXC_ODD 5
`define PBF_TXC_CRC 4
`define PBF_RXC_BASE 8'h40
`define PBF_RXC_ODD 5

// receive status word fields
`define PBF_ST_ALGN 15
`define PBF_ST_BCAST 14
`define PBF_ST_RX_BAD_CHECKSUM 13
`define PBF_ST_ODD 12
`define PBF_ST_LONG 11
`define PBF_ST_SHORT 10
`define PBF_ST_HASH_LSB 1
`define PBF_ST_MCAST 0

// reflected ethernet checksum
`define PBF_CRC_POLY 32'hEDB88320
`define PBF_CRC_INIT 32'hFFFFFFFF
`define PBF_CRC_RESIDUE 32'hDEBB20E3

`endif

/* File: core/pbf_pkg.sv */
// types for the packet buffer frame engine
`default_nettype none
package pbf_pkg;
  typedef logic [9:0] pbf_waddr_t;
  typedef enum logic [1:0] {RX_RECV, RX_CTRL, RX_COUNT, RX_STAT} pbf_rx_st_t;
  typedef enum logic [3:0] {
    TX_IDLE, TX_CNT, TX_CNTW, TX_CTL, TX_CTLW, TX_WD, TX_WW,
    TX_LO, TX_HI, TX_ODD, TX_CRC, TX_FIN
  } pbf_tx_st_t;
  typedef struct packed {
    logic [31:0] crc;
  } pbf_crc_state_t;
endpackage
`default_nettype wire

/* File: core/pbf_crc_if.sv */
// checksum engine request and result bundle
`default_nettype none
interface pbf_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [31:0] crc;
  modport user (output init, output en, output data, input crc);
  modport engine (input init, input en, input data, output crc);
endinterface
`default_nettype wire

/* File: core/pbf_crc32.sv */
// byte-wide reflected checksum engine
`default_nettype none
`include "pbf_defines.svh"
module pbf_crc32 (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  pbf_crc_if.engine crc_if
);
  import pbf_pkg::*;

  pbf_crc_state_t s_q;
  pbf_crc_state_t s_d;

  always_comb
  begin
    logic [31:0] c;
    c = crc_if.init ? `PBF_CRC_INIT : s_q.crc;
    if (crc_if.en)
    begin
      for (int i = 0; i < 8; i++)
      begin
        c = (c >> 1) ^ ((c[0] ^ crc_if.data[i]) ? `PBF_CRC_POLY : 32'h0);
      end
    end
    s_d.crc = c;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  assign crc_if.crc = s_q.crc;
endmodule
`default_nettype wire

/* File: core/pbf_frame_engine.sv */
// packet buffer frame writer (receive) and reader (transmit)
//
// Overview of operation
// - packets: status word, count word, then data
// - received checksum stored right after data, then control
// - count halved equals packet word total
// - strip option drops checksum from count
// - packet never exceeds one 2048 byte page
// - receive count even; odd flag marks last byte
// - transmit count bit zero treated as zero
// - data starts at byte four, max 2043
// - length/type field passed through untouched
// - odd flag decides whether last byte goes
// - per-packet checksum flag honoured only when suppressed
// - receive control byte: bit6 one, odd bit5
// - receive status written into first word
// - alignment error; bad checksum or receive error
// - broadcast flag set for broadcast frames
// - too long above 1518, too short below 64
// - six-bit hash from checksum over destination
// - hash 5:3 picks byte, 2:0 picks bit
// - multicast flag; table hit accepts frame
// - device writes status/results, host writes transmit
`default_nettype none
`include "pbf_defines.svh"
module pbf_frame_engine #(
  parameter logic [11:0] MIN_FRAME = `PBF_MIN_FRAME,
  parameter logic [11:0] MAX_FRAME = `PBF_MAX_FRAME
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_er_i,
  input wire logic rx_align_err_i,
  input wire logic rx_checksum_strip_i,
  input wire logic rx_filter_pass_i,
  input wire logic [63:0] mcast_table_i,
  output logic rxm_we_o,
  output pbf_pkg::pbf_waddr_t rxm_addr_o,
  output logic [15:0] rxm_wdata_o,
  output logic rx_done_o,
  output logic rx_accept_o,
  input wire logic tx_start_i,
  input wire logic tx_auto_checksum_suppress_i,
  input wire logic [15:0] tx_status_i,
  output logic txm_rd_o,
  output logic txm_we_o,
  output pbf_pkg::pbf_waddr_t txm_addr_o,
  output logic [15:0] txm_wdata_o,
  input wire logic [15:0] txm_rdata_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic tx_done_o
);
  import pbf_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    pbf_rx_st_t rst;
    logic [11:0] n;
    logic [11:0] dlen;
    logic capped;
    logic [7:0] lo;
    logic [39:0] hist;
    logic er;
    logic algn;
    logic bcast;
    logic mcast;
    logic [5:0] hash;
    logic we;
    pbf_waddr_t waddr;
    logic [15:0] wdata;
    logic done;
    logic accept;
    pbf_tx_st_t tst;
    logic [10:0] tcnt;
    logic [7:0] tctl;
    logic [7:0] todd;
    logic [15:0] tword;
    logic [1:0] ci;
    logic rd;
    logic twe;
    pbf_waddr_t taddr;
    logic [15:0] twd;
    logic tv;
    logic [7:0] tb;
    logic tlast;
    logic tdone;
  } pbf_top_state_t;

  pbf_top_state_t s_q;
  pbf_top_state_t s_d;

  pbf_crc_if rxc ();
  pbf_crc_if txc ();

  pbf_crc32 u_rx_crc (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .crc_if(rxc.engine)
  );

  pbf_crc32 u_tx_crc (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .crc_if(txc.engine)
  );

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    logic [11:0] nt;
    logic [11:0] d0;
    logic [7:0] lastb;
    logic [31:0] fcs;
    logic can;
    logic append;
    logic odd;
    nt = '0;
    d0 = '0;
    lastb = '0;
    fcs = ~txc.crc;
    can = !s_q.tv || tx_ready_i;
    append = !tx_auto_checksum_suppress_i || s_q.tctl[`PBF_TXC_CRC];
    odd = s_q.tctl[`PBF_TXC_ODD];
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.done = 1'b0;
    s_d.rd = 1'b0;
    s_d.twe = 1'b0;
    s_d.tdone = 1'b0;
    if (tx_ready_i)
    begin
      s_d.tv = 1'b0;
      s_d.tlast = 1'b0;
    end
    rxc.init = (s_q.n == 12'h000);
    rxc.en = (s_q.rst == RX_RECV) && rx_valid_i;
    rxc.data = rx_data_i;
    txc.init = 1'b0;
    txc.en = 1'b0;
    txc.data = 8'h00;

    // -----------------------------------------------------------------
    // receive: bytes are stored raw, length/type is never looked at
    // -----------------------------------------------------------------
    case (s_q.rst)
      RX_RECV:
      begin
        if (rx_valid_i)
        begin
          nt = (s_q.n == 12'hFFF) ? s_q.n : s_q.n + 12'h001;
          s_d.n = nt;
          s_d.hist = {s_q.hist[31:0], rx_data_i};
          s_d.er = ((s_q.n == 12'h000) ? 1'b0 : s_q.er) | rx_er_i;
          s_d.algn = ((s_q.n == 12'h000) ? 1'b0 : s_q.algn)
            | rx_align_err_i;
          if (s_q.n < `PBF_DA_BYTES)
            s_d.bcast = ((s_q.n == 12'h000) ? 1'b1 : s_q.bcast)
              & (rx_data_i == 8'hFF);
          if (s_q.n == 12'h000)
            s_d.mcast = rx_data_i[0];
          if (s_q.n == `PBF_DA_BYTES)
            s_d.hash = rxc.crc[31:26];
          // bytes past the page limit are dropped, checks still run
          if (s_q.n < `PBF_MAX_DATA)
          begin
            if (!s_q.n[0])
              s_d.lo = rx_data_i;
            else
            begin
              s_d.we = 1'b1;
              s_d.waddr = `PBF_DATA_IDX + s_q.n[10:1];
              s_d.wdata = {rx_data_i, s_q.lo};
            end
          end
          if (rx_last_i)
          begin
            d0 = rx_checksum_strip_i ? nt - `PBF_CRC_BYTES : nt;
            s_d.capped = (d0 > `PBF_MAX_DATA);
            s_d.dlen = (d0 > `PBF_MAX_DATA) ? `PBF_MAX_DATA : d0;
            s_d.rst = RX_CTRL;
          end
        end
      end
      RX_CTRL:
      begin
        // with stripping and no capping the last data byte sits four bytes back
        lastb = (rx_checksum_strip_i && !s_q.capped) ?
          s_q.hist[39:32] : s_q.lo;
        s_d.we = 1'b1;
        s_d.waddr = `PBF_DATA_IDX + s_q.dlen[10:1];
        s_d.wdata[15:8] = `PBF_RXC_BASE;
        s_d.wdata[8 + `PBF_RXC_ODD] = s_q.dlen[0];
        s_d.wdata[7:0] = s_q.dlen[0] ? lastb : 8'h00;
        s_d.rst = RX_COUNT;
      end
      RX_COUNT:
      begin
        s_d.we = 1'b1;
        s_d.waddr = `PBF_COUNT_IDX;
        s_d.wdata = {4'h0, s_q.dlen[0] ? s_q.dlen + `PBF_TRL_ODD
          : s_q.dlen + `PBF_TRL_EVEN};
        s_d.rst = RX_STAT;
      end
      RX_STAT:
      begin
        s_d.we = 1'b1;
        s_d.waddr = `PBF_STATUS_IDX;
        s_d.wdata = 16'h0000;
        s_d.wdata[`PBF_ST_ALGN] = s_q.algn;
        s_d.wdata[`PBF_ST_BCAST] = s_q.bcast;
        s_d.wdata[`PBF_ST_RX_BAD_CHECKSUM] = (rxc.crc != `PBF_CRC_RESIDUE)
          | s_q.er;
        s_d.wdata[`PBF_ST_ODD] = s_q.dlen[0];
        s_d.wdata[`PBF_ST_LONG] = (s_q.n > MAX_FRAME);
        s_d.wdata[`PBF_ST_SHORT] = (s_q.n < MIN_FRAME);
        s_d.wdata[`PBF_ST_HASH_LSB +: 6] = s_q.hash;
        s_d.wdata[`PBF_ST_MCAST] = s_q.mcast;
        // table bit index equals byte*8+bit of the hash
        s_d.accept = rx_filter_pass_i
          | (s_q.mcast & mcast_table_i[s_q.hash]);
        s_d.done = 1'b1;
        s_d.n = 12'h000;
        s_d.rst = RX_RECV;
      end
      default:
        s_d.rst = RX_RECV;
    endcase

    // -----------------------------------------------------------------
    // transmit: count, then control word, then data words
    // -----------------------------------------------------------------
    case (s_q.tst)
      TX_IDLE:
      begin
        if (tx_start_i)
        begin
          txc.init = 1'b1;
          s_d.rd = 1'b1;
          s_d.taddr = `PBF_COUNT_IDX;
          s_d.tst = TX_CNT;
        end
      end
      TX_CNT:
        s_d.tst = TX_CNTW;
      TX_CNTW:
      begin
        // count bit 0 never reaches the word math
        s_d.tcnt = txm_rdata_i[11:1] - `PBF_HDR_WORDS;
        s_d.rd = 1'b1;
        s_d.taddr = pbf_waddr_t'(txm_rdata_i[11:1] - 11'h001);
        s_d.tst = TX_CTL;
      end
      TX_CTL:
        s_d.tst = TX_CTLW;
      TX_CTLW:
      begin
        s_d.tctl = txm_rdata_i[15:8];
        s_d.todd = txm_rdata_i[7:0];
        s_d.taddr = `PBF_DATA_IDX;
        if (s_q.tcnt == 11'h000)
          s_d.tst = TX_ODD;
        else
        begin
          s_d.rd = 1'b1;
          s_d.tst = TX_WD;
        end
      end
      TX_WD:
        s_d.tst = TX_WW;
      TX_WW:
      begin
        s_d.tword = txm_rdata_i;
        s_d.tst = TX_LO;
      end
      TX_LO:
      begin
        if (can)
        begin
          s_d.tv = 1'b1;
          s_d.tb = s_q.tword[7:0];
          s_d.tlast = 1'b0;
          txc.en = 1'b1;
          txc.data = s_q.tword[7:0];
          s_d.tst = TX_HI;
        end
      end
      TX_HI:
      begin
        if (can)
        begin
          s_d.tv = 1'b1;
          s_d.tb = s_q.tword[15:8];
          s_d.tlast = (s_q.tcnt == 11'h001) && !odd && !append;
          txc.en = 1'b1;
          txc.data = s_q.tword[15:8];
          s_d.tcnt = s_q.tcnt - 11'h001;
          // skip the odd stage when nothing follows, so status comes at once
          if (s_q.tcnt == 11'h001)
            s_d.tst = (odd || append) ? TX_ODD : TX_FIN;
          else
          begin
            s_d.rd = 1'b1;
            s_d.taddr = s_q.taddr + 10'h001;
            s_d.tst = TX_WD;
          end
        end
      end
      TX_ODD:
      begin
        if (!odd)
          s_d.tst = append ? TX_CRC : TX_FIN;
        else if (can)
        begin
          s_d.tv = 1'b1;
          s_d.tb = s_q.todd;
          s_d.tlast = !append;
          txc.en = 1'b1;
          txc.data = s_q.todd;
          s_d.tst = append ? TX_CRC : TX_FIN;
        end
      end
      TX_CRC:
      begin
        if (can)
        begin
          s_d.tv = 1'b1;
          s_d.tb = fcs[8 * s_q.ci +: 8];
          s_d.tlast = (s_q.ci == 2'h3);
          s_d.ci = s_q.ci + 2'h1;
          if (s_q.ci == 2'h3)
            s_d.tst = TX_FIN;
        end
      end
      TX_FIN:
      begin
        // status is written only once the last byte has left
        if (can)
        begin
          s_d.twe = 1'b1;
          s_d.taddr = `PBF_STATUS_IDX;
          s_d.twd = tx_status_i;
          s_d.tdone = 1'b1;
          s_d.ci = 2'h0;
          s_d.tst = TX_IDLE;
        end
      end
      default:
        s_d.tst = TX_IDLE;
    endcase
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign rxm_we_o = s_q.we;
  assign rxm_addr_o = s_q.waddr;
  assign rxm_wdata_o = s_q.wdata;
  assign rx_done_o = s_q.done;
  assign rx_accept_o = s_q.accept;
  assign txm_rd_o = s_q.rd;
  assign txm_we_o = s_q.twe;
  assign txm_addr_o = s_q.taddr;
  assign txm_wdata_o = s_q.twd;
  assign tx_valid_o = s_q.tv;
  assign tx_data_o = s_q.tb;
  assign tx_last_o = s_q.tlast;
  assign tx_done_o = s_q.tdone;
endmodule
`default_nettype wire

/* File: testbench/pbf_frame_engine_properties.sv */
// port assertions for the packet buffer frame engine
`default_nettype none
module pbf_frame_props (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic rx_filter_pass_i,
  input wire logic [63:0] mcast_table_i,
  input wire logic rxm_we_o,
  input wire pbf_pkg::pbf_waddr_t rxm_addr_o,
  input wire logic [15:0] rxm_wdata_o,
  input wire logic rx_done_o,
  input wire logic rx_accept_o,
  input wire logic [15:0] tx_status_i,
  input wire logic txm_we_o,
  input wire pbf_pkg::pbf_waddr_t txm_addr_o,
  input wire logic [15:0] txm_wdata_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic tx_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbf_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_status_last:
    assert property (rx_done_o |-> rxm_we_o && rxm_addr_o == 10'h000
      && $past(rxm_addr_o) == 10'h001) else $error("status order");
  a_count_even:
    assert property (rxm_we_o && rxm_addr_o == 10'h001 |->
      !rxm_wdata_o[0] && rxm_wdata_o <= 16'h0800) else $error("count");
  a_ctrl_byte:
    assert property (rxm_we_o && rxm_addr_o == 10'h001 |-> $past(rxm_we_o)
      && ($past(rxm_wdata_o[15:8]) & 8'hDF) == 8'h40) else $error("ctrl");
  a_ctrl_index:
    assert property (rxm_we_o && rxm_addr_o == 10'h001 |->
      $past(rxm_addr_o) == 10'(rxm_wdata_o[11:1] - 11'h001))
      else $error("ctrl index");
  a_odd_agree:
    assert property (rx_done_o |->
      rxm_wdata_o[12] == $past(rxm_wdata_o[13], 2))
      else $error("odd flag");
  a_accept_rule:
    assert property (rx_done_o |-> rx_accept_o == (rx_filter_pass_i
      | rxm_wdata_o[0] & mcast_table_i[rxm_wdata_o[6:1]])) else $error("acc");
  a_tx_finish:
    assert property (tx_done_o |-> txm_we_o && txm_addr_o == 10'h000
      && txm_wdata_o == tx_status_i
      && $past(tx_valid_o && tx_ready_i && tx_last_o)) else $error("tx end");
  a_tx_hold:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
      && $stable(tx_data_o) && $stable(tx_last_o)) else $error("tx hold");
  a_freeze_hold:
    assert property (!ce_i |=> $stable(tx_valid_o) && $stable(tx_data_o)
      && $stable(txm_addr_o) && $stable(tx_done_o)) else $error("freeze");
endmodule

bind pbf_frame_engine pbf_frame_props u_props (.*);
`default_nettype wire

/* File: testbench/pbf_host_mem.sv */
// host side buffer memory model for the frame engine
`default_nettype none
module pbf_host_mem (
  input wire logic sys_clk_i,
  input wire logic ce_i,
  input wire logic rxm_we_i,
  input wire pbf_pkg::pbf_waddr_t rxm_addr_i,
  input wire logic [15:0] rxm_wdata_i,
  input wire logic txm_rd_i,
  input wire logic txm_we_i,
  input wire pbf_pkg::pbf_waddr_t txm_addr_i,
  input wire logic [15:0] txm_wdata_i,
  output logic [15:0] txm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbf_pkg::*;
  logic [15:0] rx_mem [1024];
  logic [15:0] tx_mem [1024];
  logic [15:0] word_q = 16'h0000;
  // idle read bus flips each enabled cycle so a late sample never matches
  always @(posedge sys_clk_i)
  begin
    // only the read register sits behind the engine's clock enable; writes are not gated
    if (ce_i)
      word_q <= txm_rd_i ? tx_mem[txm_addr_i] : ~word_q;
    if (txm_we_i)
      tx_mem[txm_addr_i] <= txm_wdata_i;
    if (rxm_we_i)
      rx_mem[rxm_addr_i] <= rxm_wdata_i;
  end
  assign txm_rdata_o = word_q;
  // host builds a transmit packet; junk lands in don't-care bits
  task automatic put_tx(input logic [7:0] b[$], input logic crc,
                        input logic [2:0] junk);
    int n;
    n = b.size();
    tx_mem[1] = 16'(n - n % 2 + 6) | 16'(junk[0]);
    for (int i = 0; i < n / 2; i++)
      tx_mem[2 + i] = {b[2*i+1], b[2*i]};
    tx_mem[2 + n/2] = {junk[2:1], 1'(n % 2), crc, 4'h0,
                       n % 2 ? b[n-1] : 8'hA5};
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_pbf_frame_engine.sv */
// self-checking bench for the packet buffer frame engine
`default_nettype none
module test_pbf_frame_engine;
  timeunit 1ns;
  timeprecision 1ns;
  import pbf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic rx_valid_i, rx_last_i, rx_er_i, rx_align_err_i, rx_checksum_strip_i;
  logic rx_filter_pass_i, tx_start_i, tx_auto_checksum_suppress_i, tx_ready_i;
  logic rxm_we_o, rx_done_o, rx_accept_o, txm_rd_o, txm_we_o;
  logic tx_valid_o, tx_last_o, tx_done_o;
  logic [7:0] rx_data_i, tx_data_o;
  logic [63:0] mcast_table_i;
  logic [15:0] tx_status_i, txm_rdata_i, rxm_wdata_o, txm_wdata_o;
  pbf_waddr_t rxm_addr_o, txm_addr_o;
  int failures = 0;
  int checks = 0;
  int lens[6] = '{10, 63, 64, 1518, 1519, 2049};
  int tls[4] = '{1, 2, 13, 14};

  pbf_frame_engine DUT (.*);
  pbf_host_mem host (
    .sys_clk_i, .ce_i, .rxm_we_i(rxm_we_o), .rxm_addr_i(rxm_addr_o),
    .rxm_wdata_i(rxm_wdata_o), .txm_rd_i(txm_rd_o), .txm_we_i(txm_we_o),
    .txm_addr_i(txm_addr_o), .txm_wdata_i(txm_wdata_o),
    .txm_rdata_o(txm_rdata_i)
  );

  always #25 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] d);
    c ^= {24'h0, d};
    for (int k = 0; k < 8; k++)
      c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_hi(ref logic s);
    for (int n = 0; s !== 1'b1; n++)
    begin
      if (n > 3000)
      begin
        failures++;
        wrap_up();
      end
      @(negedge sys_clk_i);
    end
  endtask

  task automatic rx_frame(int len, logic strip, logic bad, logic bc);
    logic [7:0] b[$];
    logic [31:0] c;
    logic [5:0] h;
    logic er, al;
    int d;
    c = 32'hFFFFFFFF;
    er = $urandom % 8 == 0;
    al = $urandom % 8 == 0;
    for (int i = 0; i < len - 4; i++)
    begin
      b.push_back(bc && i < 6 ? 8'hFF : 8'($urandom));
      c = crc_upd(c, b[i]);
      if (i == 5)
        h = c[31:26];
    end
    c = ~c;
    for (int i = 0; i < 4; i++)
      b.push_back(c[8*i +: 8] ^ {7'h0, bad && i == 0});
    rx_checksum_strip_i = strip;
    mcast_table_i = {$urandom, $urandom};
    rx_filter_pass_i = $urandom % 2;
    foreach (b[i])
    begin
      @(negedge sys_clk_i);
      rx_valid_i = 1'b1;
      rx_data_i = b[i];
      rx_last_i = i == len - 1;
      rx_er_i = er && i == 3;
      rx_align_err_i = al && i == 2;
    end
    @(negedge sys_clk_i);
    rx_valid_i = 1'b0;
    rx_last_i = 1'b0;
    wait_hi(rx_done_o);
    d = strip ? len - 4 : len;
    d = d > 2043 ? 2043 : d;
    chk("accept", 16'(rx_filter_pass_i | b[0][0] & mcast_table_i[h]),
        16'(rx_accept_o));
    @(negedge sys_clk_i);
    chk("status", {al, bc, bad | er, 1'(d % 2), len > 1518, len < 64, 3'h0,
        h, b[0][0]}, host.rx_mem[0]);
    chk("count", 16'(d + 6 - d % 2), host.rx_mem[1]);
    for (int i = 0; i < d / 2; i++)
      chk("data", {b[2*i+1], b[2*i]}, host.rx_mem[2 + i]);
    chk("control", {2'b01, 1'(d % 2), 5'h00, d % 2 ? b[d-1] : 8'h00},
        host.rx_mem[2 + d/2]);
  endtask

  task automatic tx_frame(int n);
    logic [7:0] b[$], got[$];
    logic [31:0] c;
    logic crc, fin;
    c = 32'hFFFFFFFF;
    fin = 1'b0;
    crc = $urandom % 2;
    for (int i = 0; i < n; i++)
    begin
      b.push_back(8'($urandom));
      c = crc_upd(c, b[i]);
    end
    host.put_tx(b, crc, 3'($urandom));
    tx_auto_checksum_suppress_i = $urandom % 2;
    if (!tx_auto_checksum_suppress_i || crc)
      for (int i = 0; i < 4; i++)
        b.push_back(~c[8*i +: 8]);
    tx_status_i = 16'($urandom);
    @(negedge sys_clk_i);
    tx_start_i = 1'b1;
    repeat (9000)
    begin
      @(negedge sys_clk_i);
      tx_start_i = 1'b0;
      // random freezes; a byte only moves on an enabled edge
      ce_i = $urandom % 8 != 0;
      tx_ready_i = $urandom % 4 != 0;
      if (tx_valid_o && tx_ready_i && ce_i)
        got.push_back(tx_data_o);
      if (tx_valid_o && tx_ready_i && ce_i && tx_last_o)
      begin
        fin = 1'b1;
        break;
      end
    end
    if (!fin)
    begin
      failures++;
      wrap_up();
    end
    wait_hi(tx_done_o);
    chk("tx length", 16'(b.size()), 16'(got.size()));
    foreach (got[i])
      chk("tx byte", 16'(b[i]), 16'(got[i]));
    @(negedge sys_clk_i);
    chk("tx status", tx_status_i, host.tx_mem[0]);
  endtask

  initial
  begin
    {rx_valid_i, rx_last_i, rx_er_i, rx_align_err_i} = 4'h0;
    {rx_checksum_strip_i, rx_filter_pass_i, tx_start_i} = 3'h0;
    {tx_auto_checksum_suppress_i, tx_ready_i} = 2'h0;
    rx_data_i = 8'h00;
    mcast_table_i = 64'h0;
    tx_status_i = 16'h0000;
    void'($urandom(22949));
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    foreach (lens[i])
      rx_frame(lens[i], i % 2, i == 4, i == 3);
    repeat (20)
      rx_frame(10 + $urandom % 120, $urandom % 2, $urandom % 4 == 0,
               $urandom % 8 == 0);
    foreach (tls[i])
      tx_frame(tls[i]);
    repeat (12)
      tx_frame(1 + $urandom % 80);
    wrap_up();
  end
endmodule
`default_nettype wire
